// ===== wdps_pkg.sv
// Package for the watchdog and power-fail supervisor.
// Assumes a single 200 MHz system clock and an 8-bit register port.
package wdps_pkg;

  // Register indices on the plain register port
  localparam logic [2:0] WDPS_ADDR_WATCHDOG_CONTROL_REGISTER = 3'h0;  // Watchdog control register
  localparam logic [2:0] WDPS_ADDR_PWR   = 3'h1;  // Power control register
  localparam logic [2:0] WDPS_ADDR_EXT   = 3'h2;  // Extended interrupt register
  localparam logic [2:0] WDPS_ADDR_CLK   = 3'h3;  // Clock control register
  localparam logic [2:0] WDPS_ADDR_ISTAT = 3'h4;  // Sticky event status
  localparam logic [2:0] WDPS_ADDR_IMASK = 3'h5;  // Event mask
  localparam logic [2:0] WDPS_ADDR_CNT   = 3'h6;  // Counter top byte, read only

  // Watchdog control register bits
  localparam int WDPS_BIT_RESTART  = 0;
  localparam int WDPS_BIT_RST_EN   = 1;
  localparam int WDPS_BIT_CAUSE    = 2;
  localparam int WDPS_BIT_TIMEOUT  = 3;
  localparam int WDPS_BIT_PF_FLAG  = 4;
  localparam int WDPS_BIT_PF_EN    = 5;
  localparam int WDPS_BIT_POWER_ON = 6;
  // Other register bits
  localparam int WDPS_BIT_POF      = 4;   // Power control register
  localparam int WDPS_BIT_PDOWN    = 1;   // Power control register
  localparam int WDPS_BIT_KEEP     = 0;   // Extended interrupt register
  localparam int WDPS_BIT_IVL_LO   = 6;   // Clock control register
  localparam int WDPS_BIT_IVL_HI   = 7;   // Clock control register
  localparam int WDPS_BIT_WD_IEN   = 0;   // Event mask/enable sources

  // Event status bit positions
  localparam int WDPS_EV_TIMEOUT   = 0;
  localparam int WDPS_EV_WDRESET   = 1;
  localparam int WDPS_EV_PFAIL     = 2;
  localparam int WDPS_EV_W         = 3;

  // Timing
  localparam int WDPS_STARTUP_CYC  = 65536;  // Clocks after supply rise
  localparam int WDPS_DELAY_CYC    = 512;    // Time-out to watchdog reset
  localparam int WDPS_PULSE_CYC    = 30;     // Watchdog reset length
  localparam int WDPS_CNT_W        = 27;     // Counter width
  localparam int WDPS_IVL0_EXP     = 17;     // Interval select 00
  localparam int WDPS_IVL1_EXP     = 20;     // Interval select 01
  localparam int WDPS_IVL2_EXP     = 23;     // Interval select 10
  localparam int WDPS_IVL3_EXP     = 26;     // Interval select 11
  localparam logic [15:0] WDPS_RESET_VECTOR = 16'h0000;  // First fetch address

  // Reset values
  localparam logic [7:0] WDPS_RST_EXT = 8'h01;  // Keep-alive set
  localparam logic [1:0] WDPS_RST_IVL = 2'h0;   // Shortest interval

  // Supervisor sequence states
  typedef enum logic [1:0] {
    WDPS_ST_HOLD,    // Supply below reset threshold
    WDPS_ST_START,   // Start-up wait
    WDPS_ST_RUN,     // Normal execution
    WDPS_ST_WDRST    // Watchdog reset pulse
  } wdps_state_t;

  // Register port request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } wdps_req_t;

  // Interval select to time-out tap
  function automatic logic [4:0] wdps_tap(input logic [1:0] sel);
    case (sel)
      2'h0:    wdps_tap = 5'(WDPS_IVL0_EXP);
      2'h1:    wdps_tap = 5'(WDPS_IVL1_EXP);
      2'h2:    wdps_tap = 5'(WDPS_IVL2_EXP);
      default: wdps_tap = 5'(WDPS_IVL3_EXP);
    endcase
  endfunction : wdps_tap

endpackage : wdps_pkg

// ===== wdps_sync.sv
// Two flip-flop synchroniser for a group of level inputs.
// Assumes the inputs are asynchronous levels from analog comparators.
`timescale 1ns/1ps
`default_nettype none
module wdps_sync #(
  parameter int W = 2                  // Number of levels
) (
  input  wire logic         sys_clk,   // System clock
  input  wire logic         rst_n,     // Synchronous reset, active low
  input  wire logic [W-1:0] async_in,  // Raw levels
  output logic      [W-1:0] sync_out   // Synchronised levels
);
  logic [W-1:0] meta;                  // First stage, read only by second

  // Two stages, reset to zero
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule : wdps_sync
`default_nettype wire

// ===== wdps_top.sv
// Watchdog counter and power-fail supervisor, digital side.
// Assumes comparator levels arrive asynchronously; registers on a plain port.
`timescale 1ns/1ps
`default_nettype none
module wdps_top
  import wdps_pkg::*;
#(
  parameter int STARTUP_CYC = WDPS_STARTUP_CYC, // Start-up wait, shortenable
  parameter int CNT_TRIM    = 0                 // Bits cut from every interval, 0 in silicon
) (
  input  wire logic        sys_clk,          // System clock
  input  wire logic        rst_n,            // Power-on reset, synchronous
  input  wire logic        supply_low_rst,   // Supply below reset threshold
  input  wire logic        supply_low_pf,    // Supply below power-fail level
  input  wire logic        global_irq_en,    // Global interrupt enable, gates wd_irq only
  input  wire logic [2:0]  reg_addr,         // Register index
  input  wire logic [7:0]  reg_wdata,        // Write data
  input  wire logic        reg_wr,           // Write strobe
  input  wire logic        reg_rd,           // Read strobe
  output logic      [7:0]  reg_rdata,        // Read data, cycle after strobe
  output logic             cpu_reset,        // Core held in reset
  output logic      [15:0] start_addr,       // Fetch address after reset
  output logic             wd_irq,           // Watchdog interrupt request
  output logic             pf_irq,           // Power-fail interrupt, top priority
  output logic             detector_on,      // Supply detector powered
  output logic             irq               // Summary of unmasked events
);

  localparam int DLY_W = $clog2(WDPS_DELAY_CYC + 1);  // Delay counter width
  localparam int PUL_W = $clog2(WDPS_PULSE_CYC + 1);  // Pulse counter width
  localparam int STU_W = $clog2(STARTUP_CYC + 1);     // Start-up counter width
  localparam logic [DLY_W-1:0] DLY_LAST = DLY_W'(WDPS_DELAY_CYC - 1);
  localparam logic [PUL_W-1:0] PUL_LAST = PUL_W'(WDPS_PULSE_CYC - 1);
  localparam logic [STU_W-1:0] STU_LAST = STU_W'(STARTUP_CYC - 1);

  wdps_req_t            req;             // Bundled register request
  logic [1:0]           lvl;             // Synchronised comparator levels
  logic                 low_rst;         // Supply below reset threshold
  logic                 low_pf;          // Supply below power-fail level
  wdps_state_t          state;           // Supervisor sequence
  wdps_state_t          next_state;      // Next sequence state
  logic [STU_W-1:0]     stu_cnt;         // Start-up wait counter
  logic [PUL_W-1:0]     pul_cnt;         // Watchdog reset pulse counter
  logic [DLY_W-1:0]     dly_cnt;         // Time-out to reset delay
  logic                 dly_run;         // Reset delay pending
  logic [WDPS_CNT_W-1:0] wd_cnt;         // Watchdog counter
  logic                 wd_enabled;      // Watchdog running
  logic                 restart;         // Restart request bit
  logic                 rst_en;          // Watchdog reset enable
  logic                 cause;           // Watchdog reset cause flag
  logic                 timeout;         // Time-out flag
  logic                 pf_en;           // Power-fail interrupt enable
  logic                 power_on;        // Power-on flag
  logic                 pdown;           // Power-down request
  logic [7:0]           ext_reg;         // Extended interrupt register
  logic [1:0]           ivl;             // Interval select
  logic                 wd_ien;          // Watchdog interrupt enable
  logic [WDPS_EV_W-1:0] istat;           // Sticky event status
  logic [WDPS_EV_W-1:0] imask;           // Event mask
  logic                 rollover;        // Selected length rolls over
  logic                 wr_watchdog_control_register;        // Write to watchdog control
  logic                 wd_fire;         // Watchdog reset starts
  logic                 in_reset;        // Any reset phase active
  logic [WDPS_EV_W-1:0] ev;              // Event pulses this cycle

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // Comparator levels cross into the clock domain
  wdps_sync #(.W(2)) wdps_sync_i (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .async_in ({supply_low_pf, supply_low_rst}),
    .sync_out (lvl)
  );
  assign low_rst = lvl[0];
  assign low_pf  = lvl[1];

  // Rollover on the selected tap: lower bits all ones
  always_comb begin
    logic [4:0] tap;
    tap      = wdps_tap(ivl) - 5'(CNT_TRIM);
    rollover = wd_enabled && ((wd_cnt & ((WDPS_CNT_W'(1) << tap) - WDPS_CNT_W'(1)))
                              == ((WDPS_CNT_W'(1) << tap) - WDPS_CNT_W'(1)));
  end

  assign wr_watchdog_control_register = req.wr && (req.addr == WDPS_ADDR_WATCHDOG_CONTROL_REGISTER);
  assign wd_fire  = dly_run && (dly_cnt == DLY_LAST) && rst_en && !restart;
  assign in_reset = (state != WDPS_ST_RUN);

  // Supervisor sequence
  always_comb begin
    next_state = state;
    case (state)
      WDPS_ST_HOLD:  if (!low_rst) next_state = WDPS_ST_START;
      WDPS_ST_START: if (stu_cnt == STU_LAST) next_state = WDPS_ST_RUN;
      WDPS_ST_RUN:   if (wd_fire) next_state = WDPS_ST_WDRST;
      WDPS_ST_WDRST: if (pul_cnt == PUL_LAST) next_state = WDPS_ST_RUN;
      default:       next_state = WDPS_ST_HOLD;
    endcase
    if (low_rst) next_state = WDPS_ST_HOLD;
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) state <= WDPS_ST_HOLD;
    else        state <= next_state;
  end

  // Start-up wait counter
  always_ff @(posedge sys_clk) begin
    if (!rst_n || state != WDPS_ST_START) stu_cnt <= '0;
    else                                  stu_cnt <= stu_cnt + STU_W'(1);
  end

  // Watchdog reset pulse counter
  always_ff @(posedge sys_clk) begin
    if (!rst_n || state != WDPS_ST_WDRST) pul_cnt <= '0;
    else                                  pul_cnt <= pul_cnt + PUL_W'(1);
  end

  // Watchdog enable: power reset disables, a write of the restart bit arms it
  always_ff @(posedge sys_clk) begin
    if (!rst_n || state == WDPS_ST_HOLD) begin
      wd_enabled <= 1'b0;
    end else if (wr_watchdog_control_register && req.wdata[WDPS_BIT_RESTART]) begin
      wd_enabled <= 1'b1;
    end
  end

  // Watchdog counter
  always_ff @(posedge sys_clk) begin
    if (!rst_n || state == WDPS_ST_HOLD) begin
      wd_cnt <= '0;
    end else if (restart || state == WDPS_ST_WDRST) begin
      wd_cnt <= '0;
    end else if (wd_enabled) begin
      wd_cnt <= wd_cnt + WDPS_CNT_W'(1);
    end
  end

  // Restart bit: set by software, cleared once the counter is cleared
  always_ff @(posedge sys_clk) begin
    if (!rst_n || state == WDPS_ST_HOLD) restart <= 1'b0;
    else if (wr_watchdog_control_register && req.wdata[WDPS_BIT_RESTART]) restart <= 1'b1;
    else restart <= 1'b0;
  end

  // Delay from time-out to watchdog reset
  always_ff @(posedge sys_clk) begin
    if (!rst_n || in_reset || restart) begin
      dly_run <= 1'b0;
      dly_cnt <= '0;
    end else if (rollover && !dly_run) begin
      dly_run <= 1'b1;
      dly_cnt <= '0;
    end else if (dly_run) begin
      dly_run <= (dly_cnt != DLY_LAST);
      dly_cnt <= dly_cnt + DLY_W'(1);
    end
  end

  // Watchdog control bits written by software
  always_ff @(posedge sys_clk) begin
    if (!rst_n || state == WDPS_ST_HOLD) begin
      rst_en <= 1'b0;
      pf_en  <= 1'b0;
    end else if (wr_watchdog_control_register) begin
      rst_en <= req.wdata[WDPS_BIT_RST_EN];
      pf_en  <= req.wdata[WDPS_BIT_PF_EN];
    end
  end

  // Time-out flag: set wins over a software clear
  always_ff @(posedge sys_clk) begin
    if (!rst_n || state == WDPS_ST_HOLD) timeout <= 1'b0;
    else if (rollover) timeout <= 1'b1;
    else if (wr_watchdog_control_register && !req.wdata[WDPS_BIT_TIMEOUT]) timeout <= 1'b0;
  end

  // Cause flag: set by a watchdog reset, kept over it
  always_ff @(posedge sys_clk) begin
    if (!rst_n || state == WDPS_ST_HOLD) cause <= 1'b0;
    else if (wd_fire) cause <= 1'b1;
    else if (wr_watchdog_control_register && !req.wdata[WDPS_BIT_CAUSE]) cause <= 1'b0;
  end

  // Power-on flag, seen in two registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n || state == WDPS_ST_HOLD) begin
      power_on <= 1'b1;
    end else if (wr_watchdog_control_register && !req.wdata[WDPS_BIT_POWER_ON]) begin
      power_on <= 1'b0;
    end else if (req.wr && req.addr == WDPS_ADDR_PWR && !req.wdata[WDPS_BIT_POF]) begin
      power_on <= 1'b0;
    end
  end

  // Power, extended and clock control registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n || state == WDPS_ST_HOLD) begin
      pdown   <= 1'b0;
      ext_reg <= WDPS_RST_EXT;
      ivl     <= WDPS_RST_IVL;
      wd_ien  <= 1'b0;
    end else if (req.wr) begin
      if (req.addr == WDPS_ADDR_PWR) pdown <= req.wdata[WDPS_BIT_PDOWN];
      if (req.addr == WDPS_ADDR_EXT) ext_reg <= req.wdata;
      if (req.addr == WDPS_ADDR_CLK) ivl <= req.wdata[WDPS_BIT_IVL_HI:WDPS_BIT_IVL_LO];
      if (req.addr == WDPS_ADDR_IMASK) wd_ien <= req.wdata[WDPS_BIT_WD_IEN];
    end
  end

  // Event pulses for the sticky status
  always_comb begin
    ev                  = '0;
    ev[WDPS_EV_TIMEOUT] = rollover;
    ev[WDPS_EV_WDRESET] = wd_fire;
    ev[WDPS_EV_PFAIL]   = low_pf;
  end

  // Sticky status, write one to clear; a new event wins
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      istat <= '0;
      imask <= '0;
    end else begin
      if (req.wr && req.addr == WDPS_ADDR_ISTAT)
        istat <= (istat & ~req.wdata[WDPS_EV_W-1:0]) | ev;
      else
        istat <= istat | ev;
      if (req.wr && req.addr == WDPS_ADDR_IMASK) imask <= req.wdata[WDPS_EV_W-1:0];
    end
  end

  // Registered outputs
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cpu_reset   <= 1'b1;
      start_addr  <= WDPS_RESET_VECTOR;
      wd_irq      <= 1'b0;
      pf_irq      <= 1'b0;
      detector_on <= 1'b1;
      irq         <= 1'b0;
    end else begin
      cpu_reset   <= (next_state != WDPS_ST_RUN);
      start_addr  <= WDPS_RESET_VECTOR;
      wd_irq      <= timeout && wd_ien && global_irq_en;
      pf_irq      <= low_pf && pf_en;
      detector_on <= ext_reg[WDPS_BIT_KEEP] || !pdown;
      irq         <= |(istat & imask);
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (req.rd) begin
      case (req.addr)
        WDPS_ADDR_WATCHDOG_CONTROL_REGISTER: reg_rdata <= {1'b0, power_on, pf_en, low_pf,
                                       timeout, cause, rst_en, restart};
        WDPS_ADDR_PWR:   reg_rdata <= {3'h0, power_on, 2'h0, pdown, 1'b0};
        WDPS_ADDR_EXT:   reg_rdata <= ext_reg;
        WDPS_ADDR_CLK:   reg_rdata <= {ivl, 6'h00};
        WDPS_ADDR_ISTAT: reg_rdata <= {5'h00, istat};
        WDPS_ADDR_IMASK: reg_rdata <= {5'h00, imask};
        WDPS_ADDR_CNT:   reg_rdata <= wd_cnt[WDPS_CNT_W-1 -: 8];
        default:         reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule : wdps_top
`default_nettype wire

// ===== wdps_top_checker.sv
// Port-level assertions for the watchdog and power-fail supervisor.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module wdps_top_checker
  import wdps_pkg::*;
#(
  parameter int STARTUP_CYC = 16  // Start-up wait handed on from the design
) (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        supply_low_rst,
  input wire logic        supply_low_pf,
  input wire logic        global_irq_en,
  input wire logic [2:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        cpu_reset,
  input wire logic [15:0] start_addr,
  input wire logic        wd_irq,
  input wire logic        pf_irq,
  input wire logic        detector_on,
  input wire logic        irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [31:0] hi_cnt;  // Consecutive cycles with the core held
  // Length of the current reset stretch
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !cpu_reset) begin
      hi_cnt <= 32'h0;
    end else begin
      hi_cnt <= hi_cnt + 32'h1;
    end
  end
  chk_start_vector: assert property (start_addr == 16'h0000)
    else $error("fetch address not zero");
  chk_reset_len: assert property ($fell(cpu_reset) |->
    (hi_cnt == 32'd30 || hi_cnt >= 32'(STARTUP_CYC))) else $error("reset stretch too short");
  chk_supply_hold: assert property (supply_low_rst |-> ##[1:4] cpu_reset)
    else $error("core not held while supply low");
  chk_pf_release: assert property (!supply_low_pf [*5] |=> !pf_irq)
    else $error("power-fail request without low supply");
  chk_wd_gate: assert property (!global_irq_en |=> !wd_irq)
    else $error("watchdog request with global enable off");
  chk_no_early: assert property ($rose(wd_irq) |-> !cpu_reset [*8])
    else $error("watchdog reset too early");
  chk_keep_alive: assert property (reg_wr && reg_addr == WDPS_ADDR_EXT &&
    reg_wdata[WDPS_BIT_KEEP] |=> ##[0:1] detector_on) else $error("detector off");
  chk_restart_self: assert property (reg_wr && reg_addr == WDPS_ADDR_WATCHDOG_CONTROL_REGISTER &&
    reg_wdata[WDPS_BIT_RESTART] ##2 (reg_rd && reg_addr == WDPS_ADDR_WATCHDOG_CONTROL_REGISTER)
    |=> !reg_rdata[WDPS_BIT_RESTART]) else $error("restart bit stuck");
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  chk_unmapped: assert property (reg_rd && reg_addr == 3'h7 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule : wdps_top_checker
bind wdps_top wdps_top_checker #(.STARTUP_CYC(STARTUP_CYC)) wdps_top_checker_i (.*);
`default_nettype wire

// ===== wdps_top_tb.sv
// Self-checking bench for the watchdog and power-fail supervisor.
// Assumes the checker is bound in; read results are queued and compared later.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
  $display("CHECK FAILED at %0t: got %h expected %h", $time, (a), (b)); end end
module wdps_top_tb;
  import wdps_pkg::*;
  localparam int STARTUP = 16;  // Shortened start-up wait
  logic        sys_clk, rst_n, supply_low_rst, supply_low_pf, global_irq_en;
  logic [2:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic        reg_wr, reg_rd, cpu_reset, wd_irq, pf_irq, detector_on, irq, rd_pend;
  logic [15:0] start_addr;
  logic [15:0] exp_q[$];  // Expected read value and compare mask
  int          fail_count, tests_run, n;
  integer      seed;
  logic [7:0]  r;
  // Intervals cut by 7 bits so select 00 is 1024 clocks and 01 is 8192
  wdps_top #(.STARTUP_CYC(STARTUP), .CNT_TRIM(7)) wdps_top_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .supply_low_rst(supply_low_rst), .supply_low_pf(supply_low_pf),
    .global_irq_en(global_irq_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_reset(cpu_reset),
    .start_addr(start_addr), .wd_irq(wd_irq), .pf_irq(pf_irq),
    .detector_on(detector_on), .irq(irq));
  // Clock at 200 MHz
  always #2.5 sys_clk = ~sys_clk;
  // Read data stands in the cycle after the strobe only
  always @(posedge sys_clk) begin
    if (rd_pend) begin
      if (exp_q.size() == 0) begin
        `CHK(1'b0, 1'b1)
      end else begin
        `CHK(reg_rdata & exp_q[0][7:0], exp_q[0][15:8] & exp_q[0][7:0])
        void'(exp_q.pop_front());
      end
    end
    rd_pend <= reg_rd;
  end
  task automatic results;
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] v, input logic [7:0] m);
    exp_q.push_back({v, m});
    @(posedge sys_clk);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask : rd
  task automatic tick(input int c);
    repeat (c) @(posedge sys_clk);
    #1;
  endtask : tick
  // Bounded wait for cpu_reset (sel 0) or wd_irq (sel 1) to reach v
  task automatic wait_sig(input bit sel, input logic v, input int lim, output int cnt);
    cnt = 0;
    while ((sel ? wd_irq : cpu_reset) !== v && cnt < lim) begin
      tick(1);
      cnt++;
    end
    if (cnt >= lim) begin
      fail_count++;
      $display("CHECK FAILED at %0t: wait ran out", $time);
      results();
    end
  endtask : wait_sig
  initial begin
    sys_clk = 0; rst_n = 0; supply_low_rst = 0; supply_low_pf = 0; global_irq_en = 0;
    reg_addr = 0; reg_wdata = 0; reg_wr = 0; reg_rd = 0; rd_pend = 0;
    fail_count = 0; tests_run = 0; seed = 32'h57e6b415;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    wait_sig(0, 1'b0, 200, n);
    `CHK(n inside {[STARTUP:STARTUP+8]}, 1'b1)
    `CHK(start_addr, 16'h0000)
    rd(WDPS_ADDR_WATCHDOG_CONTROL_REGISTER, 8'h40, 8'h5D);
    rd(WDPS_ADDR_PWR, 8'h10, 8'h10);
    rd(WDPS_ADDR_EXT, 8'h01, 8'h01);
    rd(WDPS_ADDR_CLK, 8'h00, 8'hC0);
    rd(3'h7, 8'h00, 8'hFF);
    wr(WDPS_ADDR_WATCHDOG_CONTROL_REGISTER, 8'h00);
    rd(WDPS_ADDR_WATCHDOG_CONTROL_REGISTER, 8'h00, 8'h40);
    for (int i = 0; i < 4; i++) begin
      wr(WDPS_ADDR_CLK, {i[1:0], 6'h00});
      rd(WDPS_ADDR_CLK, {i[1:0], 6'h00}, 8'hC0);
    end
    wr(WDPS_ADDR_CLK, 8'h00);
    repeat (4) begin
      r = 8'($random(seed));
      wr(WDPS_ADDR_IMASK, r);
      rd(WDPS_ADDR_IMASK, r, 8'h07);
    end
    // Power-fail level with the enable off, then on without global enable
    wr(WDPS_ADDR_IMASK, 8'h04);
    supply_low_pf <= 1'b1;
    tick(6);
    `CHK(pf_irq, 1'b0)
    rd(WDPS_ADDR_WATCHDOG_CONTROL_REGISTER, 8'h10, 8'h10);
    wr(WDPS_ADDR_WATCHDOG_CONTROL_REGISTER, 8'h20);
    tick(4);
    `CHK(pf_irq, 1'b1)
    `CHK(irq, 1'b1)
    rd(WDPS_ADDR_ISTAT, 8'h04, 8'h04);
    supply_low_pf <= 1'b1;
    @(posedge sys_clk);
    supply_low_pf <= 1'b0;
    tick(6);
    `CHK(pf_irq, 1'b0)
    rd(WDPS_ADDR_WATCHDOG_CONTROL_REGISTER, 8'h20, 8'h30);
    wr(WDPS_ADDR_ISTAT, 8'h04);
    tick(3);
    `CHK(irq, 1'b0)
    // Detector gating in power-down
    wr(WDPS_ADDR_PWR, 8'h02);
    tick(3);
    `CHK(detector_on, 1'b1)
    wr(WDPS_ADDR_EXT, 8'h00);
    tick(3);
    `CHK(detector_on, 1'b0)
    wr(WDPS_ADDR_PWR, 8'h00);
    tick(3);
    `CHK(detector_on, 1'b1)
    wr(WDPS_ADDR_EXT, 8'h01);
    // Supply drop below the reset threshold and recovery
    @(posedge sys_clk);
    supply_low_rst <= 1'b1;
    tick(8);
    `CHK(cpu_reset, 1'b1)
    @(posedge sys_clk);
    supply_low_rst <= 1'b0;
    wait_sig(0, 1'b0, 200, n);
    `CHK(n inside {[STARTUP:STARTUP+8]}, 1'b1)
    rd(WDPS_ADDR_WATCHDOG_CONTROL_REGISTER, 8'h40, 8'h40);
    // Watchdog with interrupt and reset enabled
    wr(WDPS_ADDR_IMASK, 8'h03);
    global_irq_en <= 1'b1;
    wr(WDPS_ADDR_WATCHDOG_CONTROL_REGISTER, 8'h03);
    rd(WDPS_ADDR_WATCHDOG_CONTROL_REGISTER, 8'h02, 8'h0B);
    wait_sig(1, 1'b1, 2000, n);
    `CHK(n inside {[1010:1030]}, 1'b1)
    wait_sig(0, 1'b1, 600, n);
    `CHK(n inside {[505:515]}, 1'b1)
    wait_sig(0, 1'b0, 100, n);
    `CHK(n inside {[29:31]}, 1'b1)
    rd(WDPS_ADDR_WATCHDOG_CONTROL_REGISTER, 8'h0C, 8'h4C);
    rd(WDPS_ADDR_ISTAT, 8'h03, 8'h03);
    @(posedge sys_clk);
    global_irq_en <= 1'b0;
    tick(3);
    `CHK(wd_irq, 1'b0)
    `CHK(irq, 1'b1)
    wr(WDPS_ADDR_WATCHDOG_CONTROL_REGISTER, 8'h00);
    wr(WDPS_ADDR_ISTAT, 8'h07);
    tick(3);
    `CHK(irq, 1'b0)
    // Restart inside the 512-cycle delay cancels the reset
    wr(WDPS_ADDR_WATCHDOG_CONTROL_REGISTER, 8'h03);
    tick(1100);
    wr(WDPS_ADDR_WATCHDOG_CONTROL_REGISTER, 8'h03);
    tick(600);
    `CHK(cpu_reset, 1'b0)
    // Select 01 as a polled timer with global interrupt enable and reset off
    wr(WDPS_ADDR_CLK, 8'h40);
    wr(WDPS_ADDR_WATCHDOG_CONTROL_REGISTER, 8'h01);
    tick(8000);
    rd(WDPS_ADDR_WATCHDOG_CONTROL_REGISTER, 8'h00, 8'h0C);
    tick(300);
    rd(WDPS_ADDR_WATCHDOG_CONTROL_REGISTER, 8'h08, 8'h0C);
    tick(600);
    `CHK(cpu_reset, 1'b0)
    tick(4);
    results();
  end
endmodule : wdps_top_tb
`default_nettype wire
